// *** manchester_sample_link.sv ***
`timescale 1ns/100ps
module manchester_sample_link (
  input wire logic i_clk,                 // System clock, 50 MHz
  input wire logic i_resetn,              // Synchronous reset, active low
  input wire logic i_link_clk,            // Link clock, twice bit rate
  input wire logic i_serial_result_out,   // Converter serial result pin
  output logic o_conversion_trigger,      // Converter trigger pin
  output logic o_shift_clk,               // Converter shift clock pin
  output logic o_line,                    // Manchester line level
  output logic o_bit_clk,                 // Retimed bit clock
  output manchester_sample_link_pkg::sample_s o_sample, // Last sample
  output logic o_sample_valid             // One-cycle pulse, new sample
);
  import manchester_sample_link_pkg::*;

  // Link-domain reset, taken over from the system reset
  logic lrst_m_q, lrst_q;
  logic link_rstn;

  always_ff @(posedge i_link_clk) begin
    lrst_m_q <= i_resetn;
    lrst_q <= lrst_m_q;
  end
  assign link_rstn = lrst_q;

  // Converter result pin synchroniser
  logic sdo_m_q, sdo_s_q;

  always_ff @(posedge i_link_clk) begin
    if (!link_rstn) begin
      sdo_m_q <= 1'H0;
      sdo_s_q <= 1'H0;
    end else begin
      sdo_m_q <= i_serial_result_out;
      sdo_s_q <= sdo_m_q;
    end
  end

  // Frame sequencer state
  frame_state_e st_q, st_d;
  logic ph_q, ph_d;
  logic [BIT_CNT_W-1:0] bit_q, bit_d;
  logic [SAMPLE_BITS-1:0] tx_q, tx_d;
  logic [SAMPLE_BITS-1:0] adc_q, adc_d;
  logic [SAMPLE_BITS-1:0] hold_q, hold_d;
  logic tog_q, tog_d;
  logic trig_q, trig_d;
  logic sck_q, sck_d;
  logic rise_q, rise_d;
  logic rise1_q, rise1_d;
  logic cell_data;
  logic bit_end;

  // Next-state logic of the link side
  always_comb begin
    st_d = st_q;
    tx_d = tx_q;
    hold_d = hold_q;
    tog_d = tog_q;
    bit_end = ph_q;
    ph_d = ~ph_q;
    bit_d = bit_q;
    cell_data = 1'H0;
    if (bit_end) begin
      bit_d = (bit_q == LAST_FRAME_BIT) ? BIT_ZERO : bit_q + BIT_ONE;
    end
    unique case (st_q)
      // 31 zeros exceed the 18 needed
      ST_ZEROS: begin
        cell_data = 1'H0;
        if (bit_end && bit_q == LAST_ZERO_BIT) begin
          st_d = ST_START;
        end
      end
      ST_START: begin
        cell_data = START_LEVEL;
        if (bit_end) begin
          st_d = ST_DATA;
          tx_d = adc_q;
          hold_d = adc_q;
          tog_d = ~tog_q; // Hold stays put 48 bits: safe for crossing
        end
      end
      ST_DATA: begin
        cell_data = tx_q[SAMPLE_BITS-1];
        if (bit_end) begin
          tx_d = {tx_q[SAMPLE_BITS-2:0], 1'H0};
          if (bit_q == LAST_FRAME_BIT) begin
            st_d = ST_ZEROS;
          end
        end
      end
    endcase
  end

  // Converter read during the zero run
  always_comb begin
    // Trigger high starts, low enables output
    trig_d = (st_q == ST_ZEROS) && (bit_q < CONVERSION_TRIGGER_BITS);
    // Only 16 shift clocks, so no zero bits read
    sck_d = !ph_q && (st_q == ST_ZEROS) &&
            (bit_q >= SCK_FIRST) && (bit_q <= SCK_LAST);
    rise_d = sck_d && !sck_q;
    rise1_d = rise_q;
    adc_d = adc_q;
    // Bit captured at shift clock rise
    if (rise1_q) begin
      adc_d = {adc_q[SAMPLE_BITS-2:0], sdo_s_q};
    end
  end

  // Link-side registers only
  always_ff @(posedge i_link_clk) begin
    if (!link_rstn) begin
      st_q <= ST_ZEROS;
      ph_q <= 1'H0;
      bit_q <= BIT_ZERO;
      tx_q <= '0;
      adc_q <= '0;
      hold_q <= '0;
      tog_q <= 1'H0;
      trig_q <= 1'H0;
      sck_q <= 1'H0;
      rise_q <= 1'H0;
      rise1_q <= 1'H0;
    end else begin
      st_q <= st_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      tx_q <= tx_d;
      adc_q <= adc_d;
      hold_q <= hold_d;
      tog_q <= tog_d;
      trig_q <= trig_d;
      sck_q <= sck_d;
      rise_q <= rise_d;
      rise1_q <= rise1_d;
    end
  end

  assign o_conversion_trigger = trig_q;
  assign o_shift_clk = sck_q;

  // Cell level is phase XOR data
  manchester_encoder u_encoder (
    .i_clk(i_link_clk),
    .i_resetn(link_rstn),
    .i_bit_clk(ph_q),
    .i_bit_data(cell_data),
    .o_line(o_line),
    .o_bit_clk(o_bit_clk)
  );

  // System side: toggle synchroniser and sample capture
  logic tog_m_q, tog_s_q, tog_p_q;
  logic tog_p_d;
  sample_s smp_q, smp_d;
  logic vld_q, vld_d;

  always_comb begin
    tog_p_d = tog_s_q;
    vld_d = tog_s_q ^ tog_p_q;
    smp_d = smp_q;
    if (tog_s_q ^ tog_p_q) begin
      smp_d.data = hold_q; // Written with the toggle, stable until the next frame
    end
  end

  // System-side registers only
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      tog_m_q <= 1'H0;
      tog_s_q <= 1'H0;
      tog_p_q <= 1'H0;
      smp_q <= '0;
      vld_q <= 1'H0;
    end else begin
      tog_m_q <= tog_q;
      tog_s_q <= tog_m_q;
      tog_p_q <= tog_p_d;
      smp_q <= smp_d;
      vld_q <= vld_d;
    end
  end

  assign o_sample = smp_q;
  assign o_sample_valid = vld_q;
endmodule

// *** manchester_sample_link_pkg.sv ***
// Functional notes
// - Line level is bit clock XOR cell data (zero, start or sample bit) in every cell.
// - Clock and data are registered together before the XOR.
// - Frame is 31 zeros, one start bit, 16 sample bits: 48 bits.
// - Reference transmit bit clock runs at 1 MHz.
// - At least 18 zero bits precede every start bit.
// - Receiver clock limit 20 MHz caps bit clock at 2.5 MHz.
// - Converter changes bits on shift clock fall; we capture on rise.
// - Extra shift clocks with trigger low only yield zero bits.
package manchester_sample_link_pkg;

  // Frame layout in bit cells
  localparam int ZERO_BITS = 31;
  localparam int START_BITS = 1;
  localparam int SAMPLE_BITS = 16;
  localparam int FRAME_BITS = ZERO_BITS + START_BITS + SAMPLE_BITS;
  localparam int MIN_ZERO_BITS = 18;
  localparam int BIT_CNT_W = 6;
  localparam logic [BIT_CNT_W-1:0] LAST_ZERO_BIT = 6'(ZERO_BITS - 1);
  localparam logic [BIT_CNT_W-1:0] LAST_FRAME_BIT = 6'(FRAME_BITS - 1);
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 6'H00;
  localparam logic [BIT_CNT_W-1:0] BIT_ONE = 6'H01;
  localparam logic START_LEVEL = 1'H1;

  // Rates: the link clock carries two half cells per bit
  // Reference bit rate
  localparam longint BIT_RATE_HZ = 1_000_000;
  localparam longint LINK_CLK_HZ = 2 * BIT_RATE_HZ;
  localparam longint RX_OVERSAMPLE = 8;
  localparam longint RX_CLK_MAX_HZ = 20_000_000;
  localparam longint BIT_RATE_MAX_HZ = RX_CLK_MAX_HZ / RX_OVERSAMPLE;
  localparam longint RX_CLK_FAST_HZ = 160_000_000;

  // Conversion time, rounded up to whole bit cells
  localparam longint T_CONVERSION_TRIGGER_NS = 4000;
  localparam longint NS_PER_S = 1_000_000_000;
  localparam longint CONVERSION_TRIGGER_BITS_L =
    (T_CONVERSION_TRIGGER_NS * BIT_RATE_HZ + NS_PER_S - 1) / NS_PER_S;
  localparam logic [BIT_CNT_W-1:0] CONVERSION_TRIGGER_BITS = 6'(CONVERSION_TRIGGER_BITS_L);
  localparam logic [BIT_CNT_W-1:0] SCK_FIRST = 6'(CONVERSION_TRIGGER_BITS_L + 1);
  localparam logic [BIT_CNT_W-1:0] SCK_LAST = 6'(CONVERSION_TRIGGER_BITS_L + SAMPLE_BITS);

  // Frame sequencer states
  typedef enum logic [2:0] {
    ST_ZEROS = 3'H1,
    ST_START = 3'H2,
    ST_DATA = 3'H4
  } frame_state_e;

  typedef struct packed {
    logic [SAMPLE_BITS-1:0] data;
  } sample_s;

endpackage

// *** manchester_encoder.sv ***
`timescale 1ns/100ps
module manchester_encoder (
  input wire logic i_clk,      // Link clock, two per bit cell
  input wire logic i_resetn,   // Link-domain reset, active low
  input wire logic i_bit_clk,  // Raw bit clock level
  input wire logic i_bit_data, // Raw data level
  output logic o_line,         // Encoded line level
  output logic o_bit_clk       // Retimed bit clock
);
  import manchester_sample_link_pkg::*;

  logic clk_q, clk_d;
  logic data_q, data_d;
  logic line_q, line_d;

  always_comb begin
    clk_d = i_bit_clk;
    data_d = i_bit_data;
    line_d = clk_q ^ data_q; // Registered again: no XOR skew reaches pin
  end

  // Registers only
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      clk_q <= 1'H0;
      data_q <= 1'H0;
      line_q <= 1'H0;
    end else begin
      clk_q <= clk_d;
      data_q <= data_d;
      line_q <= line_d;
    end
  end

  assign o_line = line_q;
  assign o_bit_clk = clk_q;
endmodule

// *** manchester_sample_link_sva.sv ***
`timescale 1ns/100ps
module manchester_sample_link_sva (
  input wire logic i_clk, // Sys clock
  input wire logic i_resetn, // Reset
  input wire logic i_link_clk, // Link clock
  input wire logic i_serial_result_out, // Pin
  input wire logic o_conversion_trigger, // Trigger
  input wire logic o_shift_clk, // Shift clock
  input wire logic o_line, // Line
  input wire logic o_bit_clk, // Bit clock
  input wire manchester_sample_link_pkg::sample_s o_sample, // Word
  input wire logic o_sample_valid // Strobe
);
  import manchester_sample_link_pkg::*;
  logic [4:0] cnt_q, cnt_d;
  // Shift pulses since trigger; preset so frame one passes
  always_comb begin
    cnt_d = cnt_q;
    if (!i_resetn) cnt_d = 5'H10;
    else if (o_conversion_trigger) cnt_d = 5'H00;
    else if (o_shift_clk) cnt_d = cnt_q + 5'H01;
  end
  always_ff @(posedge i_link_clk) cnt_q <= cnt_d;
  default clocking @(posedge i_link_clk); endclocking
  default disable iff (!i_resetn);
  property p_bclk; o_bit_clk |=> !o_bit_clk; endproperty
  a_bclk: assert property (p_bclk) else $error("bclk stuck");
  property p_run; $fell(o_bit_clk) |=> o_bit_clk; endproperty
  a_run: assert property (p_run) else $error("bclk gap");
  property p_man; o_bit_clk |=> o_line != $past(o_line); endproperty
  a_man: assert property (p_man) else $error("no mid-cell edge");
  property p_conversion_trigger;
    $rose(o_conversion_trigger) |-> o_conversion_trigger[*8] ##1
      !o_conversion_trigger;
  endproperty
  a_conversion_trigger: assert property (p_conversion_trigger) else $error("trigger width");
  property p_per;
    $rose(o_conversion_trigger) |-> ##96 $rose(o_conversion_trigger);
  endproperty
  a_per: assert property (p_per) else $error("frame length");
  property p_gap; o_conversion_trigger |-> !o_shift_clk; endproperty
  a_gap: assert property (p_gap) else $error("shift in convert");
  property p_sck; o_shift_clk |=> !o_shift_clk; endproperty
  a_sck: assert property (p_sck) else $error("shift pulse");
  property p_cnt; $rose(o_conversion_trigger) |-> cnt_q == 5'H10; endproperty
  a_cnt: assert property (p_cnt) else $error("shift count");
  c_trig: cover property ($rose(o_conversion_trigger));
  c_sck: cover property ($rose(o_shift_clk));
  c_one: cover property (o_bit_clk ##1 !o_line);
endmodule
bind manchester_sample_link manchester_sample_link_sva i_sva (.*);

// *** adc_model.sv ***
`timescale 1ns/100ps
module adc_model (
  input wire logic i_conversion_trigger, // Trigger
  input wire logic i_shift_clk, // Shift clock
  input wire logic [15:0] i_word, // Value to convert
  output logic o_serial_result_out // Result pin
);
  logic [15:0] sh_q = 16'H0000;
  always @(posedge i_conversion_trigger) sh_q <= i_word;
  always @(negedge i_shift_clk) sh_q <= {sh_q[14:0], 1'H0};
  // disabled pin (trigger high) shows the inverted top bit of the loaded word
  assign o_serial_result_out = i_conversion_trigger ? ~sh_q[15] : sh_q[15];
endmodule

// *** test_manchester_sample_link.sv ***
`timescale 1ns/100ps
module test_manchester_sample_link;
  import manchester_sample_link_pkg::*;
  logic i_clk = 1'H0, i_link_clk = 1'H0, i_resetn = 1'H0;
  logic i_serial_result_out, o_conversion_trigger, o_shift_clk;
  logic o_line, o_bit_clk, o_sample_valid, d, d0 = 1'H0, bp = 1'H0;
  logic [15:0] word = 16'H0000, rxw;
  logic [15:0] qa [$];
  logic [15:0] qb [$];
  logic [15:0] rnd [$];
  sample_s o_sample;
  int n_errors, cmp_count, cyc, zc, nb, frames, nw;
  // Link clock offset so edges drift against the system clock
  initial forever #10 i_clk = ~i_clk;
  initial #3.3 forever #6 i_link_clk = ~i_link_clk;
  manchester_sample_link i_manchester_sample_link (.*);
  adc_model i_adc_model (.i_conversion_trigger(o_conversion_trigger),
    .i_shift_clk(o_shift_clk), .i_word(word),
    .o_serial_result_out(i_serial_result_out));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Fresh word after each conversion start, corners first
  always @(posedge o_conversion_trigger) begin
    qa.push_back(word);
    qb.push_back(word);
    @(negedge i_clk);
    nw++;
    word = nw == 1 ? 16'HFFFF : nw == 2 ? 16'H8001 : rnd.pop_front();
  end
  // Far receiver: data is line XOR previous bit clock
  // Samples each half cell, not eight times
  always @(posedge i_link_clk) begin
    d = o_line ^ bp;
    if (bp !== 1'H1) d0 = d;
    else begin
      check(16'(d), 16'(d0));
      if (nb > 0) begin
        rxw = {rxw[14:0], d};
        nb--;
        if (nb == 0) check(rxw, qa.pop_front());
      end else if (d && (frames == 0 || zc >= MIN_ZERO_BITS)) begin
        if (frames > 0) check(16'(zc), 16'(ZERO_BITS));
        frames++;
        nb = SAMPLE_BITS;
        zc = 0;
      end else zc = d ? 0 : zc + 1;
    end
    bp = o_bit_clk;
  end
  // System side word, and a ceiling on run length
  always @(posedge i_clk) begin
    cyc++;
    if (o_sample_valid === 1'H1) check(o_sample.data, qb.pop_front());
    if (cyc == 2000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    void'($urandom(60));
    // Draw here so the seeded thread supplies every random word
    repeat (24) rnd.push_back(16'($urandom));
    repeat (6) @(negedge i_clk);
    i_resetn = 1'H1;
    wait (frames == 12);
    wait (nb == 0);
    tally_and_finish();
  end
endmodule
